// ### hw/rpm_pkg.sv
package rpm_pkg;
  localparam logic [7:0] POWER_CONTROL_ADDR  = 8'h87;
  localparam int         POWER_DOWN_BIT      = 1;
  localparam int         IDLE_BIT            = 0;
  localparam int         GENERAL_FLAG_0_BIT  = 2;
  localparam int         GENERAL_FLAG_1_BIT  = 3;
  localparam int         BAUD_DOUBLER_BIT    = 7;
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] POWER_CONTROL_MASK  = 8'h8F;
  localparam int         OSC_PER_MACHINE     = 12;
  localparam int         RESET_MACHINE_CYC   = 2;
  localparam int         RESET_HOLD_OSC      = OSC_PER_MACHINE * RESET_MACHINE_CYC;
  localparam logic [4:0] RESET_HOLD_COUNT    = 5'(RESET_HOLD_OSC);
  typedef enum logic [1:0] {RPM_RUN, RPM_IDLE, RPM_DOWN} rpm_mode_type;
endpackage

// ### hw/rpm_clock_divider.sv
`timescale 1ns/1ps
module rpm_clock_divider
  import rpm_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // control
  input  wire logic oscRun,
  // divided phase
  output logic      coreTick
);
  // toggling phase makes the duty cycle of the input irrelevant
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      coreTick <= 1'b0;
    end else if (oscRun) begin
      coreTick <= ~coreTick;
    end
  end
endmodule // rpm_clock_divider

// ### hw/rpm_reset_power.sv
`timescale 1ns/1ps
module rpm_reset_power
  import rpm_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // external reset pin, asynchronous
  input  wire logic       resetPin,
  // special function register port
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrite,
  input  wire logic [7:0] sfrWriteData,
  output logic      [7:0] sfrReadData,
  // interrupt from the interrupt unit
  input  wire logic       enabledIrq,
  // normal strobe values from the core
  input  wire logic       addressLatchRun,
  input  wire logic       programStoreStrobeRun,
  // outputs
  output logic            coreReset,
  output logic            cpuHalt,
  output logic            periphRun,
  output logic            oscRun,
  output logic            coreTick,
  output logic            addressLatchStrobe,
  output logic            programStoreStrobe,
  output logic [7:0]      powerControl
);
  import rpm_pkg::*;

  logic         pinMeta;
  logic         pinSync;
  logic [4:0]   holdCount;
  logic         pinReset;
  rpm_mode_type mode;
  logic         pcWrite;
  logic         idleWake;

  // one decode shared by the write path and the read path
  function automatic logic isPowerControl(input logic [7:0] addr);
    return addr == POWER_CONTROL_ADDR;
  endfunction

  assign pcWrite  = sfrWrite && isPowerControl(sfrAddr);
  assign idleWake = (mode == RPM_IDLE) && enabledIrq;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
    end else begin
      pinMeta <= resetPin;
      pinSync <= pinMeta;
    end
  end

  // count runs on ref_clk, which keeps running in power-down, so a pin
  // reset can always wake the part; the board still owns start-up time
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !pinSync) begin
      holdCount <= 5'h00;
    end else if (holdCount != RESET_HOLD_COUNT - 5'h01) begin
      holdCount <= holdCount + 5'h01;
    end
  end

  // once qualified, reset stands for as long as the pin stays high
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !pinSync) begin
      pinReset <= 1'b0;
    end else if (holdCount == RESET_HOLD_COUNT - 5'h01) begin
      pinReset <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || pinReset) begin
      mode <= RPM_RUN;
    end else begin
      case (mode)
        RPM_RUN: begin
          if (pcWrite && sfrWriteData[POWER_DOWN_BIT]) begin
            mode <= RPM_DOWN;
          end else if (pcWrite && sfrWriteData[IDLE_BIT]) begin
            mode <= RPM_IDLE;
          end
        end
        RPM_IDLE: begin
          if (idleWake) begin
            mode <= RPM_RUN;
          end
        end
        RPM_DOWN: mode <= RPM_DOWN;
        default:  mode <= RPM_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || pinReset) begin
      powerControl <= POWER_CONTROL_RESET;
    end else if (pcWrite && mode == RPM_RUN) begin
      powerControl <= sfrWriteData & POWER_CONTROL_MASK;
    end else if (idleWake) begin
      powerControl[IDLE_BIT]       <= 1'b0;
      powerControl[POWER_DOWN_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sfrReadData <= 8'h00;
    end else begin
      sfrReadData <= isPowerControl(sfrAddr) ? powerControl : 8'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      coreReset <= 1'b1;
    end else begin
      coreReset <= pinReset;
    end
  end

  // halt only gates execution; state is held by the core itself
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cpuHalt   <= 1'b0;
      periphRun <= 1'b1;
      oscRun    <= 1'b1;
    end else begin
      cpuHalt   <= (mode != RPM_RUN);
      periphRun <= (mode != RPM_DOWN);
      oscRun    <= (mode != RPM_DOWN);
    end
  end

  // run values are re-timed too, so every mode shows the same latency
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      addressLatchStrobe <= 1'b1;
      programStoreStrobe <= 1'b1;
    end else begin
      case (mode)
        RPM_IDLE: begin
          addressLatchStrobe <= 1'b1;
          programStoreStrobe <= 1'b1;
        end
        RPM_DOWN: begin
          addressLatchStrobe <= 1'b0;
          programStoreStrobe <= 1'b0;
        end
        default: begin
          addressLatchStrobe <= addressLatchRun;
          programStoreStrobe <= programStoreStrobeRun;
        end
      endcase
    end
  end

  rpm_clock_divider u_divider (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .oscRun   (oscRun),
    .coreTick (coreTick)
  );
endmodule // rpm_reset_power

// ### dv/rpm_reset_power_assertions.sv
`timescale 1ns/1ps
module rpm_reset_power_checker (
  // watched ports
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       resetPin,
  input wire logic       coreReset,
  input wire logic       cpuHalt,
  input wire logic       periphRun,
  input wire logic       oscRun,
  input wire logic       addressLatchStrobe,
  input wire logic       programStoreStrobe,
  input wire logic [7:0] powerControl,
  input wire logic       coreTick,
  input wire logic       addressLatchRun,
  input wire logic       programStoreStrobeRun
);
  // run length of the raw pin; thresholds keep clear of the synchroniser slack
  logic [5:0] pinHigh;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) pinHigh <= 6'h00;
    else pinHigh <= resetPin ? pinHigh + 6'(pinHigh != 6'h3F) : 6'h00;
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_idle_entry: assert property ($rose(powerControl[0]) && !powerControl[1] |=> cpuHalt && periphRun)
    else $error("idle entry");
  a_idle_strobe: assert property (cpuHalt && periphRun |-> addressLatchStrobe && programStoreStrobe)
    else $error("idle strobes");
  a_down_halt: assert property (!periphRun |-> cpuHalt && !oscRun)
    else $error("down halt");
  a_down_pins: assert property (!periphRun && !$past(periphRun) |-> !addressLatchStrobe && !programStoreStrobe)
    else $error("down strobes");
  a_down_stay: assert property (!oscRun && pinHigh < 6'h10 |=> !oscRun)
    else $error("down exit");
  a_pin_reset: assert property (pinHigh == 6'h1C |-> coreReset && powerControl[1:0] == 2'h0 && !cpuHalt)
    else $error("pin reset");
  a_down_stop: assert property (powerControl[1] |-> ##[1:2] !oscRun && !periphRun)
    else $error("down entry");
  a_reg_spare: assert property (powerControl[6:4] == 3'h0)
    else $error("spare bits");
  a_tick_toggle: assert property ($past(rst_n) && $past(oscRun) |-> coreTick != $past(coreTick))
    else $error("tick toggle");
  a_tick_hold: assert property ($past(rst_n) && !$past(oscRun) |-> coreTick == $past(coreTick))
    else $error("tick stopped");
  a_run_strobe: assert property ($past(rst_n) && !cpuHalt |-> addressLatchStrobe == $past(addressLatchRun)
    && programStoreStrobe == $past(programStoreStrobeRun))
    else $error("run strobes");
endmodule // rpm_reset_power_checker
bind rpm_reset_power rpm_reset_power_checker rpm_reset_power_checker_i (.ref_clk, .rst_n, .resetPin, .coreReset,
  .cpuHalt, .periphRun, .oscRun, .addressLatchStrobe, .programStoreStrobe, .powerControl, .coreTick,
  .addressLatchRun, .programStoreStrobeRun);

// ### dv/rpm_board_model.sv
`timescale 1ns/1ps
module rpm_board_model (
  // pulse request
  input wire logic       ref_clk,
  input wire logic [5:0] hold,
  // reset pin
  output logic           resetPin
);
  // high from power-up so the oscillator settles first
  logic [5:0] left = 6'h1E;
  always @(posedge ref_clk) begin
    left <= hold != 6'h00 ? hold : left - 6'(left != 6'h00);
  end
  assign resetPin = left != 6'h00;
endmodule // rpm_board_model

// ### dv/test_reset_and_power_mode_control.sv
`timescale 1ns/1ps
module test_reset_and_power_mode_control;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sfrWrite = 1'b0;
  logic        enabledIrq = 1'b0;
  logic        look = 1'b0;
  logic        seen = 1'b0;
  logic        resetPin, coreReset, cpuHalt, periphRun, oscRun;
  logic [5:0]  hold = 6'h00;
  logic [1:0]  strobeRun = 2'h0;
  logic [7:0]  sfrAddr = 8'h87;
  logic [7:0]  sfrWriteData = 8'h00;
  logic [7:0]  sfrReadData, powerControl, r;
  logic [11:0] q[$];
  int          n_fail = 0;
  int          num_checks = 0;
  int          cycles = 0;
  rpm_reset_power rpm_reset_power_i (.ref_clk, .rst_n, .resetPin, .sfrAddr, .sfrWrite, .sfrWriteData, .sfrReadData,
    .enabledIrq, .addressLatchRun(strobeRun[1]), .programStoreStrobeRun(strobeRun[0]), .coreReset, .cpuHalt,
    .periphRun, .oscRun,
    .coreTick(), .addressLatchStrobe(), .programStoreStrobe(), .powerControl);
  rpm_board_model rpm_board_model_i (.ref_clk, .hold, .resetPin);
  initial forever #25 ref_clk = ~ref_clk;
  task automatic summarize;
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value status expected %h seen %h", exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
    strobeRun = 2'($urandom);
  endtask
  // write, then an interrupt or pin pulse, then read status back
  task automatic op(input logic [7:0] w, input logic irq, input logic [5:0] pin, input logic [11:0] e);
    sfrWrite = 1'b1;
    sfrWriteData = w;
    tick(1);
    sfrWrite = 1'b0;
    sfrAddr = 8'h86;
    enabledIrq = irq;
    hold = pin;
    tick(1);
    enabledIrq = 1'b0;
    hold = 6'h00;
    tick(45);
    sfrAddr = 8'h87;
    q.push_back(e);
    look = 1'b1;
    tick(1);
    look = 1'b0;
    tick(1);
  endtask
  // compare on the falling edge, where the registered outputs have settled
  always @(negedge ref_clk) begin
    if (seen) check({cpuHalt, periphRun, oscRun, coreReset, sfrReadData}, q.pop_front());
  end
  always @(posedge ref_clk) begin
    seen <= look;
    cycles <= cycles + 1;
    if (cycles == 800) begin
      n_fail++;
      summarize;
    end
  end
  initial begin
    void'($urandom(62));
    r = 8'($urandom) & 8'h8C;
    tick(12);
    rst_n = 1'b1;
    tick(45);
    op(r | 8'h70, 1'b1, 6'h00, {4'h6, r});
    op(r | 8'h01, 1'b0, 6'h00, {4'hE, r | 8'h01});
    op(8'h00, 1'b1, 6'h00, {4'h6, r});
    op(r | 8'h03, 1'b0, 6'h0A, {4'h8, r | 8'h03});
    op(8'h00, 1'b1, 6'h1E, 12'h600);
    op(8'h01, 1'b0, 6'h1E, 12'h600);
    summarize;
  end
endmodule // test_reset_and_power_mode_control
